//--- rtl/fsp_sync_port.sv
/*
  Frame sync pulse port: validates the incoming 100 Hz pulse train, marks
  frame, multiframe and full-period starts, keeps the frame number and
  repeats the pulse train for a chained station.
  Assumes i_sync_in is asynchronous and i_legacy_mode is on i_mclk.
*/
// Notes on behaviour
// - Align only after a valid pulse train
// - Repeat input on output while valid
// - 100 Hz; frame pulse 5 us to 1 ms
// - Multiframe pulse high 2 ms to 3 ms
// - Period pulse 4-5 ms; fall restarts numbering
// - Falling edge starts every frame
// - Frame start within 500 ns of fall
// - Both long classes start a multiframe
// - 12-bit frame number, wraps at 4096
// - Legacy mode: long classes treated alike
`timescale 1ns/100ps
module fsp_sync_port #(
  parameter int unsigned P_FRAME_MAX = fsp_pkg::FRAME_MAX_CYC,
  parameter int unsigned P_MF_MIN = fsp_pkg::MF_MIN_CYC,
  parameter int unsigned P_MF_MAX = fsp_pkg::MF_MAX_CYC,
  parameter int unsigned P_SP_MIN = fsp_pkg::SP_MIN_CYC,
  parameter int unsigned P_SP_MAX = fsp_pkg::SP_MAX_CYC,
  parameter int unsigned P_PER_MIN = fsp_pkg::PER_MIN_CYC,
  parameter int unsigned P_PER_MAX = fsp_pkg::PER_MAX_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sync_in,
  input wire logic i_legacy_mode,
  output logic o_sync_out,
  output logic o_sync_valid,
  output logic o_aligned,
  output logic o_frame_start,
  output logic o_multiframe_start,
  output logic o_period_start,
  output logic [fsp_pkg::SFN_W-1:0] o_system_frame_number
);
  import fsp_pkg::*;

  // ****************************************
  // Pulse classifier
  // ****************************************
  fsp_pulse_if pif ();

  fsp_pulse_classifier #(
    .P_FRAME_MAX(P_FRAME_MAX),
    .P_MF_MIN(P_MF_MIN),
    .P_MF_MAX(P_MF_MAX),
    .P_SP_MIN(P_SP_MIN),
    .P_SP_MAX(P_SP_MAX)
  ) u_classifier (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sync_in(i_sync_in),
    .ifc(pif)
  );

  // ****************************************
  // Decode
  // ****************************************
  fsp_state_type state_r, state_nxt;
  fsp_cnt_type per_cnt_r;
  logic [SFN_W-1:0] sfn_r, sfn_nxt;
  logic aligned_r, out_r, valid_r, frame_r, mf_r, sp_r;

  wire fsp_cnt_type per_lim_w = fsp_cnt_type'(P_PER_MAX + 1);
  wire good_fall_w = pif.fall & (pif.cls != CLS_NONE);
  wire spacing_ok_w = (per_cnt_r >= fsp_cnt_type'(P_PER_MIN)) &&
                      (per_cnt_r <= fsp_cnt_type'(P_PER_MAX));
  // No pulse within the period window
  wire timeout_w = (state_r != ST_LOST) && (per_cnt_r == per_lim_w);
  wire lock_w = (state_nxt == ST_LOCKED);
  wire frame_evt_w = good_fall_w & lock_w;
  // Legacy receivers see both long classes as plain multiframe marks
  wire is_mf_w = (pif.cls == CLS_MF256) | (pif.cls == CLS_MF4096);
  wire is_sp_w = (pif.cls == CLS_MF4096) & ~i_legacy_mode;
  wire [SFN_W-1:0] sfn_inc_w = sfn_r + 12'h001;
  // Multiframe mark snaps the count to the nearest multiple of 256
  wire [3:0] sfn_hi_w = sfn_inc_w[11:8] + {3'h0, sfn_inc_w[7]};
  wire fsp_cnt_type per_cnt_nxt = good_fall_w ? '0 :
                                  (per_cnt_r < per_lim_w) ? per_cnt_r + 1'b1 : per_cnt_r;

  assign sfn_nxt = !frame_evt_w ? sfn_r :
                   is_sp_w ? SFN_RST :
                   is_mf_w ? {sfn_hi_w, 8'h00} : sfn_inc_w;

  // ****************************************
  // Lock state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    if (pif.bad || timeout_w) begin
      state_nxt = ST_LOST;
    end else if (good_fall_w) begin
      case (state_r)
        ST_LOST: state_nxt = ST_ARMED;
        ST_ARMED: state_nxt = spacing_ok_w ? ST_LOCKED : ST_ARMED;
        ST_LOCKED: state_nxt = spacing_ok_w ? ST_LOCKED : ST_ARMED;
        default: state_nxt = ST_LOST;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_r <= ST_LOST;
      per_cnt_r <= '0;
      sfn_r <= SFN_RST;
      aligned_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      per_cnt_r <= per_cnt_nxt;
      sfn_r <= sfn_nxt;
      aligned_r <= aligned_r | frame_evt_w;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      out_r <= 1'b0;
      valid_r <= 1'b0;
      frame_r <= 1'b0;
      mf_r <= 1'b0;
      sp_r <= 1'b0;
    end else begin
      out_r <= lock_w & pif.level;
      valid_r <= lock_w;
      frame_r <= frame_evt_w;
      mf_r <= frame_evt_w & is_mf_w;
      sp_r <= frame_evt_w & is_sp_w;
    end
  end

  assign o_sync_out = out_r;
  assign o_sync_valid = valid_r;
  assign o_aligned = aligned_r;
  assign o_frame_start = frame_r;
  assign o_multiframe_start = mf_r;
  assign o_period_start = sp_r;
  assign o_system_frame_number = sfn_r;

  // ****************************************
  // Checks
  // ****************************************
  localparam int START_BOUND = START_MAX_CYC;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_locked_fall;
    pif.fall && pif.cls != CLS_NONE && !pif.bad && state_r == ST_LOCKED && spacing_ok_w;
  endsequence

  a_out_gated: assert property (
    o_sync_out |-> o_sync_valid && $past(pif.level))
    else $error("output repeated while not valid");

  a_start_needs_lock: assert property (
    o_frame_start |-> o_aligned && o_sync_valid && $past(pif.fall))
    else $error("frame start without valid pulse train");

  a_start_delay: assert property (
    seq_locked_fall |-> ##[1:START_BOUND] o_frame_start)
    else $error("frame start too late after falling edge");

  a_sfn_step: assert property (
    o_frame_start && !o_multiframe_start
      |-> o_system_frame_number == $past(o_system_frame_number) + 12'h001)
    else $error("frame number did not advance by one");

  a_mf_align: assert property (
    o_multiframe_start |-> o_frame_start && o_system_frame_number[7:0] == 8'h00)
    else $error("multiframe start not on multiple of 256");

  a_period_zero: assert property (
    o_period_start |-> o_multiframe_start && o_system_frame_number == SFN_RST)
    else $error("period start without frame number zero");

  a_legacy_alike: assert property (
    $past(i_legacy_mode) |-> !o_period_start)
    else $error("period marker seen in legacy mode");

  a_bad_drops: assert property (
    pif.bad |=> !o_sync_valid ##1 !o_sync_out)
    else $error("bad pulse did not drop validity");

  a_miss_drops: assert property (
    timeout_w |=> !o_sync_valid && state_r == ST_LOST)
    else $error("missing pulse did not drop validity");

endmodule : fsp_sync_port

//--- common/fsp_pkg.sv
/*
  Package for the frame sync pulse port: pulse width classes, lock states,
  timing figures and the cycle counts derived from them.
  Assumes a single 200 MHz station clock.
*/
package fsp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int CNT_W = 22;
  localparam int SFN_W = 12;
  typedef logic [CNT_W-1:0] fsp_cnt_type;

  // ****************************************
  // Timing figures in ns
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_FRAME_MIN_NS = 5000;
  localparam int T_FRAME_MAX_NS = 1000000;
  localparam int T_MF_MIN_NS = 2000000;
  localparam int T_MF_MAX_NS = 3000000;
  localparam int T_SP_MIN_NS = 4000000;
  localparam int T_SP_MAX_NS = 5000000;
  localparam int T_PERIOD_NS = 10000000;
  localparam int T_PERIOD_TOL_NS = 10000;
  localparam int T_START_MAX_NS = 500;

  // ****************************************
  // Cycle counts: least times round up, longest round down
  // ****************************************
  localparam int FRAME_MIN_CYC = (T_FRAME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_MAX_CYC = T_FRAME_MAX_NS / CLK_PERIOD_NS;
  localparam int MF_MIN_CYC = (T_MF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MF_MAX_CYC = T_MF_MAX_NS / CLK_PERIOD_NS;
  localparam int SP_MIN_CYC = (T_SP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SP_MAX_CYC = T_SP_MAX_NS / CLK_PERIOD_NS;
  localparam int PER_MIN_CYC = (T_PERIOD_NS - T_PERIOD_TOL_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int PER_MAX_CYC = (T_PERIOD_NS + T_PERIOD_TOL_NS) / CLK_PERIOD_NS;
  localparam int START_MAX_CYC = T_START_MAX_NS / CLK_PERIOD_NS;

  // ****************************************
  // Frame number reset value
  // ****************************************
  localparam logic [SFN_W-1:0] SFN_RST = 12'h000;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0,
    CLS_FRAME = 2'h1,
    CLS_MF256 = 2'h2,
    CLS_MF4096 = 2'h3
  } fsp_class_type;

  typedef enum logic [1:0] {
    ST_LOST = 2'h0,
    ST_ARMED = 2'h1,
    ST_LOCKED = 2'h3
  } fsp_state_type;

endpackage : fsp_pkg

//--- common/fsp_pulse_if.sv
/*
  Interface from the pulse classifier to the frame timing logic.
  Assumes both ends run on the same station clock.
*/
`timescale 1ns/100ps
interface fsp_pulse_if;
  import fsp_pkg::*;
  logic fall;
  logic bad;
  logic level;
  fsp_class_type cls;

  modport src (output fall, output bad, output level, output cls);
  modport snk (input fall, input bad, input level, input cls);
endinterface : fsp_pulse_if

//--- rtl/fsp_pulse_classifier.sv
/*
  Synchronises the sync input pin, measures each high time and classifies
  the pulse at its falling edge. Assumes the pin is asynchronous to i_mclk.
*/
`timescale 1ns/100ps
module fsp_pulse_classifier #(
  parameter int unsigned P_FRAME_MAX = fsp_pkg::FRAME_MAX_CYC,
  parameter int unsigned P_MF_MIN = fsp_pkg::MF_MIN_CYC,
  parameter int unsigned P_MF_MAX = fsp_pkg::MF_MAX_CYC,
  parameter int unsigned P_SP_MIN = fsp_pkg::SP_MIN_CYC,
  parameter int unsigned P_SP_MAX = fsp_pkg::SP_MAX_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sync_in,
  fsp_pulse_if.src ifc
);
  import fsp_pkg::*;

  // ****************************************
  // Synchroniser and filtered level
  // ****************************************
  logic s1_r, s2_r, s3_r, lvl_r, fall_r, bad_r;
  fsp_cnt_type hi_cnt_r;
  fsp_class_type cls_r;

  wire fsp_cnt_type lim_w = fsp_cnt_type'(P_SP_MAX + 1);
  wire lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  wire fall_w = lvl_r & ~lvl_nxt;
  wire rise_w = ~lvl_r & lvl_nxt;
  wire in_frame_w = (hi_cnt_r >= fsp_cnt_type'(FRAME_MIN_CYC)) &&
                    (hi_cnt_r <= fsp_cnt_type'(P_FRAME_MAX));
  wire in_mf_w = (hi_cnt_r >= fsp_cnt_type'(P_MF_MIN)) &&
                 (hi_cnt_r <= fsp_cnt_type'(P_MF_MAX));
  wire in_sp_w = (hi_cnt_r >= fsp_cnt_type'(P_SP_MIN)) &&
                 (hi_cnt_r <= fsp_cnt_type'(P_SP_MAX));
  wire fsp_class_type cls_w = in_frame_w ? CLS_FRAME :
                              in_mf_w ? CLS_MF256 :
                              in_sp_w ? CLS_MF4096 : CLS_NONE;
  // Still high past the longest class: flag once, before any fall
  wire stuck_w = lvl_r & lvl_nxt & (hi_cnt_r == fsp_cnt_type'(P_SP_MAX));
  wire bad_nxt = (fall_w & (cls_w == CLS_NONE)) | stuck_w;
  wire fsp_cnt_type hi_cnt_nxt = rise_w ? fsp_cnt_type'(1) :
                                 (lvl_r && hi_cnt_r < lim_w) ? hi_cnt_r + 1'b1 : hi_cnt_r;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= i_sync_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // ****************************************
  // Width measurement and classification
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      hi_cnt_r <= '0;
      fall_r <= 1'b0;
      bad_r <= 1'b0;
      cls_r <= CLS_NONE;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      fall_r <= fall_w;
      bad_r <= bad_nxt;
      cls_r <= fall_w ? cls_w : cls_r;
    end
  end

  assign ifc.fall = fall_r;
  assign ifc.bad = bad_r;
  assign ifc.level = lvl_r;
  assign ifc.cls = cls_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_level_drop;
    lvl_r ##1 !lvl_r;
  endsequence

  a_fall_marks_edge: assert property (
    seq_level_drop |-> fall_r && !$past(fall_r))
    else $error("fall pulse not aligned to level drop");

  a_class_frame: assert property (
    fall_r && cls_r == CLS_FRAME |-> $past(hi_cnt_r) >= fsp_cnt_type'(FRAME_MIN_CYC)
      && $past(hi_cnt_r) <= fsp_cnt_type'(P_FRAME_MAX))
    else $error("frame pulse width out of range");

  a_class_mf: assert property (
    fall_r && cls_r == CLS_MF256 |-> $past(hi_cnt_r) >= fsp_cnt_type'(P_MF_MIN)
      && $past(hi_cnt_r) <= fsp_cnt_type'(P_MF_MAX))
    else $error("multiframe pulse width out of range");

  a_class_period: assert property (
    fall_r && cls_r == CLS_MF4096 |-> $past(hi_cnt_r) >= fsp_cnt_type'(P_SP_MIN)
      && $past(hi_cnt_r) <= fsp_cnt_type'(P_SP_MAX))
    else $error("period pulse width out of range");

  a_bad_width: assert property (
    fall_r && cls_r == CLS_NONE |-> bad_r)
    else $error("unclassified pulse not flagged bad");

endmodule : fsp_pulse_classifier

//--- sim/fsp_sync_gen.sv
/*
  Far-side model of the sync pulse source: a time receiver or an upstream
  station driving the sync pin. Assumes the bench calls its tasks and that
  the pin idles low between pulses.
*/
`timescale 1ns/100ps
module fsp_sync_gen (
  input wire logic i_mclk,
  output logic o_sync
);
  import fsp_pkg::*;

  // ****************************************
  // Pulse widths in cycles for the shortened timing set
  // ****************************************
  function automatic int unsigned width_of(input fsp_class_type c);
    case (c)
      CLS_MF256: width_of = 2500;
      CLS_MF4096: width_of = 4500;
      default: width_of = 1200;
    endcase
  endfunction : width_of

  // ****************************************
  // Frame numbering of a time-slaved source
  // ****************************************
  // Frame number at a whole second, the same for either time source
  function automatic logic [SFN_W-1:0] sfn_at_second(input int unsigned sec);
    sfn_at_second = SFN_W'((sec * 100) % (1 << SFN_W));
  endfunction : sfn_at_second

  // Marker class for a frame number; second mod 64 lands on a multiframe
  function automatic fsp_class_type class_of(input logic [SFN_W-1:0] system_frame_number);
    if (system_frame_number == '0) begin
      class_of = CLS_MF4096;
    end else if (system_frame_number[7:0] == 8'h00) begin
      class_of = CLS_MF256;
    end else begin
      class_of = CLS_FRAME;
    end
  endfunction : class_of

  // A time stamp is only used when no integrity alert came in meanwhile
  function automatic logic stamp_usable(input logic alert_seen);
    stamp_usable = ~alert_seen;
  endfunction : stamp_usable

  // ****************************************
  // Pin driver, changes only at the falling edge
  // ****************************************
  task automatic drive(input logic v);
    @(negedge i_mclk);
    o_sync = v;
  endtask : drive

  initial begin
    o_sync = 1'b0;
  end
endmodule : fsp_sync_gen

//--- sim/testbench.sv
/*
  Self-checking bench for the frame sync pulse port with shortened counts.
  Assumes the design header and package as declared, one 200 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
  import fsp_pkg::*;

  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int unsigned PER = 10000;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_legacy_mode = 1'b0;
  logic sync_pin;
  logic o_sync_out, o_sync_valid, o_aligned;
  logic o_frame_start, o_multiframe_start, o_period_start;
  logic [SFN_W-1:0] o_system_frame_number;
  int miscompares = 0;
  int checks = 0;

  always #2.5 i_mclk = ~i_mclk;

  fsp_sync_gen gen_u (.i_mclk(i_mclk), .o_sync(sync_pin));

  fsp_sync_port #(.P_FRAME_MAX(1500), .P_MF_MIN(2000), .P_MF_MAX(3000), .P_SP_MIN(4000),
    .P_PER_MIN(9950)) dut_u (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sync_in(sync_pin),
    .i_legacy_mode(i_legacy_mode),
    .o_sync_out(o_sync_out),
    .o_sync_valid(o_sync_valid),
    .o_aligned(o_aligned),
    .o_frame_start(o_frame_start),
    .o_multiframe_start(o_multiframe_start),
    .o_period_start(o_period_start),
    .o_system_frame_number(o_system_frame_number)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Rest of one period low, then one pulse of width w; fall to fall is PER
  task automatic beat(input int unsigned w, input logic emid, input logic efs,
                      input logic emf, input logic eps, input logic evalid,
                      input logic chk_sfn, input logic [SFN_W-1:0] esfn);
    logic fs, mf, ps;
    logic [SFN_W-1:0] system_frame_number;
    fs = 1'b0;
    mf = 1'b0;
    ps = 1'b0;
    system_frame_number = '0;
    repeat (PER - w - START_MAX_CYC) @(negedge i_mclk);
    gen_u.drive(1'b1);
    repeat (w / 2) @(negedge i_mclk);
    check("sync_out mid pulse", o_sync_out, emid);
    repeat (w - w / 2 - 1) @(negedge i_mclk);
    gen_u.drive(1'b0);
    for (int i = 0; i < START_MAX_CYC; i++) begin
      @(posedge i_mclk);
      #1;
      if (o_frame_start === 1'b1 && !fs) begin
        fs = 1'b1;
        mf = o_multiframe_start;
        ps = o_period_start;
        system_frame_number = o_system_frame_number;
      end
    end
    check("frame_start", fs, efs);
    check("multiframe_start", mf, emf);
    check("period_start", ps, eps);
    check("sync_valid", o_sync_valid, evalid);
    if (chk_sfn) check("frame number", system_frame_number, esfn);
  endtask : beat

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check("outputs after reset", {o_sync_out, o_sync_valid, o_aligned, o_frame_start,
      o_multiframe_start, o_period_start}, 6'h00);
    check("frame number after reset", o_system_frame_number, SFN_RST);
  endtask : t_reset

  task automatic t_lock;
    beat(gen_u.width_of(CLS_FRAME), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, '0);
    check("aligned before lock", o_aligned, 1'b0);
    beat(gen_u.width_of(CLS_FRAME), 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 12'h001);
    check("aligned after lock", o_aligned, 1'b1);
  endtask : t_lock

  task automatic t_period;
    int unsigned w;
    w = gen_u.width_of(gen_u.class_of(gen_u.sfn_at_second(1024)));
    beat(w, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 12'h000);
    w = gen_u.width_of(CLS_FRAME);
    beat(w, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 12'h001);
    beat(w, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 12'h002);
  endtask : t_period

  task automatic t_multi;
    int unsigned w;
    w = gen_u.width_of(gen_u.class_of(gen_u.sfn_at_second(64)));
    if (gen_u.stamp_usable(1'b0)) begin
      beat(w, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 12'h000);
    end
  endtask : t_multi

  task automatic t_legacy;
    @(negedge i_mclk);
    i_legacy_mode = 1'b1;
    beat(gen_u.width_of(CLS_MF4096), 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 12'h000);
    @(negedge i_mclk);
    i_legacy_mode = 1'b0;
  endtask : t_legacy

  task automatic t_bad_width;
    beat(3500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, '0);
    check("sync_out after bad pulse", o_sync_out, 1'b0);
    check("aligned stays set", o_aligned, 1'b1);
  endtask : t_bad_width

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    @(posedge i_mclk);
    #1;
    t_reset();
    t_lock();
    t_period();
    t_multi();
    t_legacy();
    t_bad_width();
    wrap_up();
  end

  initial begin
    repeat (8 * PER + 10000) @(posedge i_mclk);
    miscompares++;
    wrap_up();
  end
endmodule : testbench
